// [core/adc_port_pkg.sv]
// Purpose: Shared constants for the converter serial host port
// Assumes: 8-bit command byte followed by one 24-bit data word per frame
// Notes:   All registers are 24 bits wide on the serial link
package adc_port_pkg;

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  localparam int unsigned COMM_BITS  = 8;
  localparam int unsigned DATA_BITS  = 24;
  localparam int unsigned ADDR_BITS  = 6;
  localparam int unsigned CNT_BITS   = 5;
  localparam int unsigned WORD_BITS  = ADDR_BITS + DATA_BITS;

  localparam logic [4:0] CNT_COMM_LAST  = 5'h07;
  localparam logic [4:0] CNT_DATA_FIRST = 5'h08;
  localparam logic [4:0] CNT_FRAME_LAST = 5'h1f;

  // Command byte fields
  localparam int unsigned COMM_NWE_BIT = 7;
  localparam int unsigned COMM_RD_BIT  = 6;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int unsigned REG_COUNT = 8;
  localparam logic [5:0] ADDR_STATUS = 6'h00;
  localparam logic [5:0] ADDR_CTRL   = 6'h01;
  localparam logic [5:0] ADDR_DATA   = 6'h02;
  localparam logic [5:0] ADDR_LIMIT  = 6'h08;

  localparam int unsigned STATUS_RDY_BIT   = 7;
  localparam int unsigned CTRL_EXT_CLK_BIT = 0;
  localparam logic [23:0] REG_RST = 24'h000000;

  // ----------------------------------------------------------------------
  // Write buffer and serial phases
  // ----------------------------------------------------------------------
  localparam int unsigned FIFO_DEPTH = 2;
  localparam logic [1:0]  FIFO_FULL  = 2'h2;

  typedef enum logic [2:0] {
    PH_COMM  = 3'b001,
    PH_WRITE = 3'b010,
    PH_READ  = 3'b100
  } phase_e;

endpackage : adc_port_pkg

// [core/adc_serial_port_ready_sync.sv]
// Purpose: Serial host port, ready signalling, filter sync and clock pin
// Assumes: sclk idles high, each sclk phase lasts at least 8 mclk cycles
// Notes:   Serial logic runs on sclk; cs_n high clears the bit position and shifters, not the toggles
//
// How it works
// - Sync low holds filter, calibration, modulator reset
// - Sync never touches serial link state
// - Sync low forces ready indication high
// - Ready falls when a conversion completes
// - Unread result: ready rises before next update
// - Output bits change on falling sclk edge
// - Output word loaded from addressed register
// - Written word goes to command-selected register; status and data ignore writes
// - Active-low select frames traffic unless held low for 3-wire use
// - Continuous or gapped sclk bursts both work
// - Clock pin drives internal clock or accepts external
`timescale 1ns/1ps
`default_nettype none

module adc_serial_port_ready_sync
  import adc_port_pkg::*;
(
  input  wire logic                           mclk,
  input  wire logic                           rst_n,
  input  wire logic                           ce,
  input  wire logic                           sclk,
  input  wire logic                           cs_n,
  input  wire logic                           din,
  output logic                                dout_rdy,
  input  wire logic                           sync_n,
  output logic                                filter_reset,
  output logic                                cal_reset,
  output logic                                modulator_reset,
  input  wire logic                           conv_done,
  input  wire logic [adc_port_pkg::DATA_BITS-1:0] conv_result,
  input  wire logic                           pre_update,
  input  wire logic                           osc_clk,
  output logic                                osc_en,
  input  wire logic                           clk_pin_i,
  output logic                                clk_pin_o,
  output logic                                clk_pin_oe,
  output logic                                conv_clk
);
  import adc_port_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic                  link_hold;
  logic                  serial_clr;
  phase_e                phase;
  logic [CNT_BITS-1:0]   bit_cnt;
  logic [DATA_BITS-1:0]  in_sr;
  logic [COMM_BITS-1:0]  comm;
  logic                  comm_ok;
  logic [ADDR_BITS-1:0]  rd_addr;
  logic [ADDR_BITS-1:0]  wr_addr;
  logic [WORD_BITS-1:0]  wr_word;
  logic                  rd_tgl;
  logic                  wr_tgl;
  logic [DATA_BITS-1:0]  out_sr;
  logic                  out_bit;

  logic [2:0]            rd_sync;
  logic [2:0]            wr_sync;
  logic [1:0]            sync_pin;
  logic [1:0]            osc_pin;
  logic [1:0]            ext_pin;
  logic                  rd_evt;
  logic                  wr_evt;
  logic                  sync_low;
  logic [DATA_BITS-1:0]  rd_word;
  logic [DATA_BITS-1:0]  result;
  logic                  ready_n;
  logic                  filt_hold;
  logic [DATA_BITS-1:0]  cfg [REG_COUNT];
  logic                  ext_clk;

  logic                  pend;
  logic [WORD_BITS-1:0]  pend_word;
  logic [WORD_BITS-1:0]  fifo_mem [FIFO_DEPTH];
  logic                  wptr;
  logic                  rptr;
  logic [1:0]            fifo_cnt;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic                  drain_ready;
  logic                  push;
  logic                  pop;
  logic [WORD_BITS-1:0]  head;
  logic [ADDR_BITS-1:0]  head_addr;

  // ----------------------------------------------------------------------
  // Link reset
  // ----------------------------------------------------------------------
  // A frame ends with cs_n high; the mclk reset also clears the link
  // so that a three-wire host starts from a known bit position.
  always_ff @(posedge mclk)
  begin
    link_hold <= ~rst_n;
  end

  assign serial_clr = cs_n | link_hold;

  // ----------------------------------------------------------------------
  // Serial receive, sclk rising edge
  // ----------------------------------------------------------------------
  assign comm    = {in_sr[COMM_BITS-2:0], din};
  assign comm_ok = ~comm[COMM_NWE_BIT];

  // Nothing here looks at sync_n, so a transfer in flight survives it
  always_ff @(posedge sclk or posedge serial_clr)
  begin
    if (serial_clr)
    begin
      bit_cnt <= '0;
      phase   <= PH_COMM;
      in_sr   <= '0;
    end
    else
    begin
      in_sr <= {in_sr[DATA_BITS-2:0], din};
      case (phase)
        PH_COMM:
        begin
          if (bit_cnt == CNT_COMM_LAST)
          begin
            // A byte with the top bit set is ignored, so idle ones realign
            if (comm_ok)
            begin
              bit_cnt <= CNT_DATA_FIRST;
              phase   <= comm[COMM_RD_BIT] ? PH_READ : PH_WRITE;
            end
            else
            begin
              bit_cnt <= '0;
            end
          end
          else
          begin
            bit_cnt <= bit_cnt + 5'h01;
          end
        end
        PH_WRITE,
        PH_READ:
        begin
          // Wrap back to a command byte; this is what frames 3-wire use
          if (bit_cnt == CNT_FRAME_LAST)
          begin
            bit_cnt <= '0;
            phase   <= PH_COMM;
          end
          else
          begin
            bit_cnt <= bit_cnt + 5'h01;
          end
        end
        default:
        begin
          bit_cnt <= '0;
          phase   <= PH_COMM;
        end
      endcase
    end
  end

  // Toggles and held words survive cs_n so no false event reaches mclk
  always_ff @(posedge sclk or posedge link_hold)
  begin
    if (link_hold)
    begin
      rd_tgl  <= 1'b0;
      wr_tgl  <= 1'b0;
      rd_addr <= '0;
      wr_addr <= '0;
      wr_word <= '0;
    end
    else if (!cs_n)
    begin
      if (phase == PH_COMM && bit_cnt == CNT_COMM_LAST && comm_ok)
      begin
        if (comm[COMM_RD_BIT])
        begin
          rd_addr <= comm[ADDR_BITS-1:0];
          rd_tgl  <= ~rd_tgl;
        end
        else
        begin
          wr_addr <= comm[ADDR_BITS-1:0];
        end
      end
      if (phase == PH_WRITE && bit_cnt == CNT_FRAME_LAST)
      begin
        wr_word <= {wr_addr, in_sr[DATA_BITS-2:0], din};
        wr_tgl  <= ~wr_tgl;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Serial transmit, sclk falling edge
  // ----------------------------------------------------------------------
  // rd_word is settled by mclk within the sclk high phase after the
  // command byte; a faster sclk would load a stale word.
  always_ff @(negedge sclk or posedge serial_clr)
  begin
    if (serial_clr)
    begin
      out_bit <= 1'b0;
      out_sr  <= '0;
    end
    else if (phase == PH_READ)
    begin
      if (bit_cnt == CNT_DATA_FIRST)
      begin
        out_bit <= rd_word[DATA_BITS-1];
        out_sr  <= {rd_word[DATA_BITS-2:0], 1'b0};
      end
      else
      begin
        out_bit <= out_sr[DATA_BITS-1];
        out_sr  <= {out_sr[DATA_BITS-2:0], 1'b0};
      end
    end
  end

  // Deselected, the pin carries the ready level instead of data
  assign dout_rdy = cs_n ? ready_n : out_bit;

  // ----------------------------------------------------------------------
  // Crossings into mclk
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rd_sync  <= '0;
      wr_sync  <= '0;
      sync_pin <= 2'h3;
      osc_pin  <= '0;
      ext_pin  <= '0;
    end
    else if (ce)
    begin
      rd_sync  <= {rd_sync[1:0], rd_tgl};
      wr_sync  <= {wr_sync[1:0], wr_tgl};
      sync_pin <= {sync_pin[0], sync_n};
      osc_pin  <= {osc_pin[0], osc_clk};
      ext_pin  <= {ext_pin[0], clk_pin_i};
    end
  end

  assign rd_evt   = rd_sync[2] ^ rd_sync[1];
  assign wr_evt   = wr_sync[2] ^ wr_sync[1];
  assign sync_low = ~sync_pin[1];

  // ----------------------------------------------------------------------
  // Filter synchronization
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      filt_hold <= 1'b0;
    end
    else if (ce)
    begin
      filt_hold <= sync_low;
    end
  end

  assign filter_reset    = filt_hold;
  assign cal_reset       = filt_hold;
  assign modulator_reset = filt_hold;

  // ----------------------------------------------------------------------
  // Result and ready indication
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      result <= REG_RST;
    end
    else if (ce && conv_done && !sync_low)
    begin
      result <= conv_result;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ready_n <= 1'b1;
    end
    else if (ce)
    begin
      if (sync_low)
      begin
        ready_n <= 1'b1;
      end
      else if (conv_done)
      begin
        ready_n <= 1'b0;
      end
      else if (pre_update || (rd_evt && rd_addr == ADDR_DATA))
      begin
        ready_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read word capture
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rd_word <= '0;
    end
    else if (ce && rd_evt)
    begin
      if (rd_addr == ADDR_STATUS)
      begin
        rd_word <= '0;
        rd_word[STATUS_RDY_BIT] <= ready_n;
      end
      else if (rd_addr == ADDR_DATA)
      begin
        rd_word <= result;
      end
      else if (rd_addr < ADDR_LIMIT)
      begin
        rd_word <= cfg[rd_addr[2:0]];
      end
      else
      begin
        rd_word <= '0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Write buffer
  // ----------------------------------------------------------------------
  // The held word changes only after another full frame, so one pending
  // slot plus two entries absorbs any stall of the register update.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pend      <= 1'b0;
      pend_word <= '0;
    end
    else if (ce)
    begin
      if (wr_evt)
      begin
        pend      <= 1'b1;
        pend_word <= wr_word;
      end
      else if (push)
      begin
        pend <= 1'b0;
      end
    end
  end

  assign fifo_in_ready  = (fifo_cnt != FIFO_FULL);
  assign fifo_out_valid = (fifo_cnt != 2'h0);
  // A landing result owns the update path for that cycle
  assign drain_ready    = ~conv_done;
  assign push           = pend & fifo_in_ready;
  assign pop            = fifo_out_valid & drain_ready;
  assign head           = fifo_mem[rptr];
  assign head_addr      = head[WORD_BITS-1:DATA_BITS];

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wptr     <= 1'b0;
      rptr     <= 1'b0;
      fifo_cnt <= 2'h0;
    end
    else if (ce)
    begin
      if (push)
      begin
        fifo_mem[wptr] <= pend_word;
        wptr           <= ~wptr;
      end
      if (pop)
      begin
        rptr <= ~rptr;
      end
      fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < REG_COUNT; gi++)
    begin : g_cfg
      always_ff @(posedge mclk)
      begin
        if (!rst_n)
        begin
          cfg[gi] <= REG_RST;
        end
        else if (ce && pop && head_addr == ADDR_BITS'(gi) &&
                 head_addr != ADDR_STATUS && head_addr != ADDR_DATA)
        begin
          cfg[gi] <= head[DATA_BITS-1:0];
        end
      end
    end
  endgenerate

  assign ext_clk = cfg[ADDR_CTRL[2:0]][CTRL_EXT_CLK_BIT];

  // ----------------------------------------------------------------------
  // Conversion clock pin
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      conv_clk   <= 1'b0;
      clk_pin_o  <= 1'b0;
      clk_pin_oe <= 1'b1;
      osc_en     <= 1'b1;
    end
    else if (ce)
    begin
      conv_clk   <= ext_clk ? ext_pin[1] : osc_pin[1];
      clk_pin_o  <= osc_pin[1];
      clk_pin_oe <= ~ext_clk;
      osc_en     <= ~ext_clk;
    end
  end

endmodule : adc_serial_port_ready_sync

`default_nettype wire

// [verif/adc_port_props.sv]
// Purpose: Pin-level checks on the converter serial port
// Assumes: sync_n, conv_done, pre_update change off mclk edges
// Notes:   Bound to the design top; watches port inputs as well as outputs
`timescale 1ns/1ps
`default_nettype none

module adc_port_props (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic dout_rdy,
  input wire logic sync_n,
  input wire logic filter_reset,
  input wire logic cal_reset,
  input wire logic modulator_reset,
  input wire logic conv_done,
  input wire logic pre_update,
  input wire logic osc_clk,
  input wire logic osc_en,
  input wire logic clk_pin_i,
  input wire logic clk_pin_o,
  input wire logic clk_pin_oe,
  input wire logic conv_clk
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sync_hold_a: assert property (!sync_n [*4] |=> filter_reset)
    else $error("filter reset missing");
  sync_free_a: assert property (sync_n [*4] |=> !filter_reset)
    else $error("filter reset stuck");
  rst_tied_a: assert property (cal_reset == filter_reset &&
    modulator_reset == filter_reset) else $error("resets differ");
  rdy_sync_a: assert property ($rose(filter_reset) |=> dout_rdy || cs_n == 0)
    else $error("ready low under sync");
  rdy_fall_a: assert property (conv_done && sync_n && $past(sync_n, 4)
    |=> !dout_rdy || !cs_n) else $error("ready did not fall");
  rdy_rise_a: assert property (pre_update && !conv_done
    |=> dout_rdy || !cs_n) else $error("ready did not rise");
  out_hold_a: assert property (!cs_n && !$past(cs_n) && !$fell(sclk)
    |-> $stable(dout_rdy)) else $error("dout moved off falling edge");
  oe_match_a: assert property (clk_pin_oe == osc_en)
    else $error("pin enable and osc enable differ");
  ext_clk_a: assert property (!clk_pin_oe && !$past(clk_pin_oe, 4)
    |-> conv_clk == $past(clk_pin_i, 3)) else $error("ext clock lost");
  int_clk_a: assert property (clk_pin_oe && $past(clk_pin_oe, 4) &&
    $past(rst_n, 4) |-> clk_pin_o == $past(osc_clk, 3))
    else $error("osc not on clock pin");

  cover property (conv_done ##1 !dout_rdy);
  cover property ($rose(filter_reset));
  cover property ($fell(clk_pin_oe));
  cover property (!cs_n && $fell(sclk));
endmodule : adc_port_props

bind adc_serial_port_ready_sync adc_port_props u_props (.*);

`default_nettype wire

// [verif/adc_serial_port_ready_sync_tb.sv]
// Purpose: Self-checking bench for the converter serial port
// Assumes: Host model runs a 125 ns sclk unrelated to mclk
// Notes:   Bench-driven control inputs change on mclk falling edges; host pins and clocks run free
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) \
  begin \
    n_checks++; \
    if ((got) !== (ex)) \
    begin \
      $display("[ERR] %s exp %h got %h", nm, ex, got); \
      n_fail++; \
    end \
  end

module adc_serial_port_ready_sync_tb;
  import adc_port_pkg::*;
  logic        mclk, rst_n, ce, sync_n, conv_done, pre_update;
  logic        osc_clk, clk_pin_i;
  logic [23:0] conv_result;
  wire logic   sclk, cs_n, din, dout_rdy, filter_reset, cal_reset;
  wire logic   modulator_reset, osc_en, clk_pin_o, clk_pin_oe, conv_clk;
  int          n_fail, n_checks;

  adc_serial_port_ready_sync DUT (.*);
  spi_host_model host (.*);

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial
  begin
    osc_clk = 1'b0;
    forever #7 osc_clk = ~osc_clk;
  end
  initial
  begin
    clk_pin_i = 1'b0;
    forever #11 clk_pin_i = ~clk_pin_i;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task automatic done(input logic [23:0] v);
    conv_result = v;
    conv_done = 1'b1;
    cyc(1);
    conv_done = 1'b0;
    cyc(2);
  endtask : done

  task automatic rd(input logic [5:0] a, output logic [23:0] d);
    host.frame({2'b01, a}, 24'h000000, 1'b0, 1'b0, d);
  endtask : rd

  task automatic wr(input logic [5:0] a, input logic [23:0] v, input bit g);
    logic [23:0] u;
    host.frame({2'b00, a}, v, g, 1'b0, u);
    cyc(8);
  endtask : wr

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_ready;
    logic [23:0] d;
    done(24'ha5c3e1);
    `CHK("rdy", 1'b0, dout_rdy)
    rd(ADDR_STATUS, d);
    `CHK("stat", 24'h000000, d)
    rd(ADDR_DATA, d);
    `CHK("res", 24'ha5c3e1, d)
    cyc(6);
    `CHK("rdy", 1'b1, dout_rdy)
    rd(ADDR_STATUS, d);
    `CHK("stat", 24'h000080, d)
    done(24'h0f0f0f);
    pre_update = 1'b1;
    cyc(1);
    pre_update = 1'b0;
    cyc(1);
    `CHK("rdy", 1'b1, dout_rdy)
  endtask : t_ready

  task automatic t_write;
    logic [23:0] d;
    wr(6'h03, 24'h123456, 1'b0);
    wr(6'h04, 24'hfedcba, 1'b1);
    wr(ADDR_DATA, 24'h777777, 1'b0);
    rd(6'h03, d);
    `CHK("r3", 24'h123456, d)
    rd(6'h04, d);
    `CHK("r4", 24'hfedcba, d)
    rd(ADDR_DATA, d);
    `CHK("ro", 24'h0f0f0f, d)
    rd(ADDR_LIMIT, d);
    `CHK("unmap", 24'h000000, d)
  endtask : t_write

  task automatic t_sync;
    logic [23:0] d;
    done(24'h335577);
    fork
      rd(6'h03, d);
      begin
        cyc(100);
        sync_n = 1'b0;
      end
    join
    `CHK("mid", 24'h123456, d)
    `CHK("flt", 1'b1, filter_reset)
    `CHK("rdy", 1'b1, dout_rdy)
    done(24'h111111);
    `CHK("ign", 1'b1, dout_rdy)
    sync_n = 1'b1;
    cyc(5);
    `CHK("flt", 1'b0, filter_reset)
  endtask : t_sync

  task automatic t_3wire;
    logic [23:0] d;
    host.frame(8'h05, 24'h00a0b0, 1'b0, 1'b1, d);
    host.frame(8'h45, 24'h000000, 1'b0, 1'b0, d);
    `CHK("3w", 24'h00a0b0, d)
  endtask : t_3wire

  task automatic t_clk;
    wr(ADDR_CTRL, 24'h000001, 1'b0);
    `CHK("oe", 1'b0, clk_pin_oe)
    cyc(40);
    wr(ADDR_CTRL, 24'h000000, 1'b0);
    `CHK("oe", 1'b1, clk_pin_oe)
  endtask : t_clk

  task automatic wrap_up;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  initial
  begin
    n_fail = 0;
    n_checks = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    sync_n = 1'b1;
    conv_done = 1'b0;
    pre_update = 1'b0;
    conv_result = 24'h000000;
    cyc(6);
    rst_n = 1'b1;
    cyc(4);
    `CHK("rst", 1'b1, dout_rdy)
    `CHK("rst", 1'b1, osc_en)
    t_ready();
    t_write();
    t_sync();
    t_3wire();
    t_clk();
    wrap_up();
  end
endmodule : adc_serial_port_ready_sync_tb

`default_nettype wire

// [verif/spi_host_model.sv]
// Purpose: Behavioural serial master on the far side of the port
// Assumes: sclk idles high; host shifts on fall, samples on rise
// Notes:   Offsets keep sclk edges off mclk rising edges
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
  output logic     sclk,
  output logic     cs_n,
  output logic     din,
  input  wire logic dout_rdy
);
  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b1;
  end

  // Gap stretches sclk high between bytes for the slow host
  task automatic frame(input logic [7:0] cmd, input logic [23:0] wd,
                       input bit gap, input bit keep,
                       output logic [23:0] rd);
    logic [31:0] sh;
    sh = {cmd, wd};
    rd = 24'h000000;
    cs_n = 1'b0;
    #41;
    for (int i = 0; i < 32; i++)
    begin
      sclk = 1'b0;
      din  = sh[31-i];
      #62.5;
      sclk = 1'b1;
      if (i > 7) rd = {rd[22:0], dout_rdy};
      #62.5;
      if (gap && i % 8 == 7) #300;
    end
    // Released line must not keep showing the last bit
    din = ~din;
    if (!keep) cs_n = 1'b1;
    #100;
  endtask : frame
endmodule : spi_host_model

`default_nettype wire
